// File: rtl/coef_map_defs.svh
// Offsets, field positions, reset values and timing counts of the coefficient map
`ifndef COEF_MAP_DEFS_SVH
`define COEF_MAP_DEFS_SVH

// Paged map
`define REG_PAGE_SEL 7'h00
`define REG_ADAPT_CFG 7'h01
`define REG_RSVD_LAST 7'h07
`define REG_COEF_FIRST 7'h08
`define PAGE_BUF_A_FIRST 8'h2c
`define PAGE_BUF_A_LAST 8'h34
`define PAGE_BUF_B_FIRST 8'h3e
`define PAGE_BUF_B_LAST 8'h46
`define COEF_PER_PAGE 9'h01e
`define COEF_LAST 9'h0ff
`define RSVD_READ_VALUE 8'h00
`define PAGE_RESET 8'h00

// Adaptive configuration fields
`define CFG_ADAPT_EN_BIT 2
`define CFG_BUF_FLAG_BIT 1
`define CFG_SWITCH_BIT 0

// Defaults valid this long after reset
`define INIT_TIME_NS 100000
`define CLK_PERIOD_NS 40
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Controller registers on APB
`define APB_CMD 8'h00
`define APB_PAGE 8'h04
`define APB_STATUS 8'h08
`define CMD_WDATA_LSB 0
`define CMD_REG_LSB 8
`define CMD_WRITE_BIT 16
`define CMD_GO_BIT 31
`define ST_BUSY_BIT 0
`define ST_REFUSED_BIT 1
`define ST_OPEN_BIT 2
`define ST_RDATA_LSB 8

`endif

// File: rtl/coef_map_pkg.sv
// Types shared by both ends of the coefficient map link
`include "coef_map_defs.svh"

package coef_map_pkg;

   typedef logic [7:0] byte_t;
   typedef logic [6:0] reg_addr_t;
   typedef logic [23:0] coef_t;

   typedef enum logic [0:0] {
      HOST_IDLE = 1'b0,
      HOST_WAIT = 1'b1
   } host_state_e;

   typedef struct packed {
      byte_t page;
      logic adapt_en;
      logic buf_b;
      logic sw_req;
      logic ack;
      byte_t rdata;
      logic [11:0] init_cnt;
      logic ready;
      logic open;
      logic active_b;
      coef_t conv_coef;
   } dev_state_s;

   typedef struct packed {
      host_state_e state;
      byte_t page;
      logic req;
      logic we;
      reg_addr_t addr;
      byte_t wdata;
      byte_t rdata;
      logic refused;
      logic pready;
      logic [31:0] prdata;
   } host_state_s;

endpackage

// File: rtl/coef_link_if.sv
// Register access link between the controller and the coefficient map
`timescale 1ns/1ns

interface coef_link_if;
   import coef_map_pkg::*;
   logic req;
   logic we;
   reg_addr_t addr;
   byte_t wdata;
   logic ack;
   byte_t rdata;
   logic open;

   modport device (
      input req,
      input we,
      input addr,
      input wdata,
      output ack,
      output rdata,
      output open
   );

   modport host (
      output req,
      output we,
      output addr,
      output wdata,
      input ack,
      input rdata,
      input open
   );
endinterface // coef_link_if

// File: rtl/coef_addr_decode.sv
// Page and register to coefficient buffer, index and byte lane
`timescale 1ns/1ns
`include "coef_map_defs.svh"

module coef_addr_decode (
   input wire coef_map_pkg::byte_t page,
   input wire coef_map_pkg::reg_addr_t reg_addr,
   output logic hit_a,
   output logic hit_b,
   output logic [7:0] idx,
   output logic [1:0] lane
);
   import coef_map_pkg::*;

   logic in_a;
   logic in_b;
   logic [8:0] page_off;
   logic [8:0] slot;
   logic [8:0] full_idx;
   logic in_range;

   always_comb begin
      in_a = (page >= `PAGE_BUF_A_FIRST) && (page <= `PAGE_BUF_A_LAST);
      in_b = (page >= `PAGE_BUF_B_FIRST) && (page <= `PAGE_BUF_B_LAST);
      page_off = in_b ? {1'b0, page - `PAGE_BUF_B_FIRST}
                      : {1'b0, page - `PAGE_BUF_A_FIRST};
      slot = {4'h0, reg_addr[6:2]} - 9'h002;
      full_idx = 9'((page_off * `COEF_PER_PAGE) + slot);
      in_range = (reg_addr >= `REG_COEF_FIRST) && (full_idx <= `COEF_LAST);
      hit_a = in_a && in_range;
      hit_b = in_b && in_range;
      idx = full_idx[7:0];
      lane = reg_addr[1:0];
   end
endmodule // coef_addr_decode

// File: rtl/coef_map_device.sv
// Coefficient memory end: paged map, two buffers and adaptive switching
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`include "coef_map_defs.svh"

module coef_map_device #(
   parameter int INIT_CYCLES = `INIT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   coef_link_if.device link,
   input wire logic dac_powered,
   input wire logic frame_strobe,
   input wire logic [7:0] conv_idx,
   output logic [23:0] conv_coef,
   output logic conv_uses_b,
   output logic adaptive_on,
   output logic defaults_ready
);
   import coef_map_pkg::*;

   if (INIT_CYCLES < 256 || INIT_CYCLES > 4095) begin : g_bad_init
      $error("INIT_CYCLES must lie in 256..4095");
   end

   coef_t mem_a [256];
   coef_t mem_b [256];
   dev_state_s state_reg;
   dev_state_s state_next;

   logic hit_a;
   logic hit_b;
   logic [7:0] idx;
   logic [1:0] lane;
   logic take;
   logic permitted;
   logic coef_wr;
   logic init_wr;
   logic [7:0] init_idx;
   coef_t cur_word;
   coef_t new_word;

   // ----------------------------------------------------------------
   // Defaults
   // ----------------------------------------------------------------
   function automatic coef_t default_coef(input logic [7:0] i);
      coef_t v;
      v = 24'h000000;
      unique case (i)
         8'h01, 8'h06, 8'h10, 8'h15, 8'h1a, 8'h21, 8'h26, 8'h2b,
         8'h30, 8'h35, 8'h41, 8'h44: v = 24'h7fffff;
         8'h0b, 8'h3a: v = 24'h7fff00;
         8'h47: v = 24'h7ff700;
         8'h48: v = 24'h100900;
         8'h49: v = 24'h7fef00;
         8'h4a, 8'h4b: v = 24'h001100;
         8'h4c: v = 24'h7fde00;
         default: v = 24'h000000;
      endcase
      return v;
   endfunction

   coef_addr_decode u_decode (
      .page(state_reg.page),
      .reg_addr(link.addr),
      .hit_a(hit_a),
      .hit_b(hit_b),
      .idx(idx),
      .lane(lane)
   );

   // ----------------------------------------------------------------
   // Access decision
   // ----------------------------------------------------------------
   always_comb begin
      take = link.req && !state_reg.ack;
      // powered-down gate, else host-side buffer only
      if (state_reg.adapt_en) begin
         permitted = state_reg.buf_b ? hit_a : hit_b;
      end else begin
         permitted = (hit_a || hit_b) && !dac_powered;
      end
      // nothing reaches the buffers before defaults land
      permitted = permitted && state_reg.ready;
      cur_word = hit_b ? mem_b[idx] : mem_a[idx];
      new_word = cur_word;
      unique case (lane)
         2'd0: new_word[23:16] = link.wdata;
         2'd1: new_word[15:8] = link.wdata;
         2'd2: new_word[7:0] = link.wdata;
         2'd3: new_word = cur_word;
      endcase
      // reserved fourth byte never touches storage
      coef_wr = take && link.we && permitted && (lane != 2'd3);
      init_wr = !state_reg.ready && (state_reg.init_cnt < 12'd256);
      init_idx = state_reg.init_cnt[7:0];
   end

   // ----------------------------------------------------------------
   // Coefficient storage
   // ----------------------------------------------------------------
   always_ff @(posedge pclk) begin
      if (init_wr) begin
         mem_a[init_idx] <= default_coef(init_idx);
         mem_b[init_idx] <= default_coef(init_idx);
      end else if (coef_wr && hit_a) begin
         mem_a[idx] <= new_word;
      end else if (coef_wr && hit_b) begin
         mem_b[idx] <= new_word;
      end
   end

   // ----------------------------------------------------------------
   // Control state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.ack = take;
      if (!state_reg.ready) begin
         // defaults declared valid after the set delay
         if (32'(state_reg.init_cnt) >= INIT_CYCLES - 1) begin
            state_next.ready = 1'b1;
         end else begin
            state_next.init_cnt = state_reg.init_cnt + 12'd1;
         end
      end
      // swap on frame, request clears itself
      if (frame_strobe && state_reg.adapt_en && state_reg.sw_req) begin
         state_next.buf_b = !state_reg.buf_b;
         state_next.sw_req = 1'b0;
      end
      if (take) begin
         state_next.rdata = `RSVD_READ_VALUE;
         if (link.addr == `REG_PAGE_SEL) begin
            state_next.rdata = state_reg.page;
            if (link.we) begin
               state_next.page = link.wdata;
            end
         end else if (link.addr == `REG_ADAPT_CFG &&
                      state_reg.page == `PAGE_BUF_A_FIRST) begin
            state_next.rdata = {5'h00, state_reg.adapt_en,
                                state_reg.buf_b, state_reg.sw_req};
            if (link.we) begin
               state_next.adapt_en = link.wdata[`CFG_ADAPT_EN_BIT];
               // a write of one arms the switch
               if (link.wdata[`CFG_SWITCH_BIT]) begin
                  state_next.sw_req = 1'b1;
               end
            end
         end else if (permitted && lane != 2'd3) begin
            unique case (lane)
               2'd0: state_next.rdata = cur_word[23:16];
               2'd1: state_next.rdata = cur_word[15:8];
               2'd2: state_next.rdata = cur_word[7:0];
               2'd3: state_next.rdata = `RSVD_READ_VALUE;
            endcase
         end
      end
      // Converter always reads A outside adaptive mode
      state_next.active_b = state_reg.adapt_en && state_next.buf_b;
      state_next.conv_coef = state_reg.active_b ? mem_b[conv_idx]
                                                : mem_a[conv_idx];
      // link shows when buffers may be reached
      state_next.open = state_next.ready &&
                        (state_next.adapt_en || !dac_powered);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
         state_reg.page <= `PAGE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign link.ack = state_reg.ack;
   assign link.rdata = state_reg.rdata;
   assign link.open = state_reg.open;
   assign conv_coef = state_reg.conv_coef;
   assign conv_uses_b = state_reg.active_b;
   assign adaptive_on = state_reg.adapt_en;
   assign defaults_ready = state_reg.ready;
endmodule // coef_map_device

// File: rtl/coef_map_host.sv
// Controller end: APB registers turned into link accesses
`timescale 1ns/1ns
`include "coef_map_defs.svh"

module coef_map_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   coef_link_if.host link
);
   import coef_map_pkg::*;

   host_state_s state_reg;
   host_state_s state_next;
   logic apb_wr;
   logic apb_rd;
   logic go;
   logic cmd_we;
   reg_addr_t cmd_reg;
   logic coef_page;
   logic deny;

   always_comb begin
      state_next = state_reg;
      // Writes act only at the edge where the master sees pready high
      apb_wr = psel && penable && pwrite && state_reg.pready;
      apb_rd = psel && penable && !pwrite && !state_reg.pready;
      state_next.pready = psel && penable && !state_reg.pready;
      cmd_we = pwdata[`CMD_WRITE_BIT];
      cmd_reg = pwdata[`CMD_REG_LSB +: 7];
      go = apb_wr && (paddr == `APB_CMD) && pwdata[`CMD_GO_BIT] &&
           state_reg.state == HOST_IDLE;
      coef_page = (state_reg.page >= `PAGE_BUF_A_FIRST &&
                   state_reg.page <= `PAGE_BUF_A_LAST) ||
                  (state_reg.page >= `PAGE_BUF_B_FIRST &&
                   state_reg.page <= `PAGE_BUF_B_LAST);
      deny = 1'b0;
      if (cmd_reg != `REG_PAGE_SEL) begin
         if (!coef_page) begin
            deny = cmd_we;
         // writes to registers 1 to 7 refused, except register 1 on page 0x2c
         end else if (cmd_reg <= `REG_RSVD_LAST) begin
            deny = cmd_we && !(cmd_reg == `REG_ADAPT_CFG &&
                               state_reg.page == `PAGE_BUF_A_FIRST);
         // buffers only while the device allows
         end else begin
            deny = !link.open;
         end
      end
      unique case (state_reg.state)
         HOST_IDLE: begin
            if (go && !deny) begin
               state_next.state = HOST_WAIT;
               state_next.req = 1'b1;
               state_next.we = cmd_we;
               state_next.addr = cmd_reg;
               state_next.wdata = pwdata[`CMD_WDATA_LSB +: 8];
            end
         end
         HOST_WAIT: begin
            if (link.ack) begin
               state_next.state = HOST_IDLE;
               state_next.req = 1'b0;
               state_next.rdata = link.rdata;
               if (state_reg.we && state_reg.addr == `REG_PAGE_SEL) begin
                  state_next.page = state_reg.wdata;
               end
            end
         end
      endcase
      // Write one clears; a new refusal in the same cycle wins
      if (apb_wr && paddr == `APB_STATUS && pwdata[`ST_REFUSED_BIT]) begin
         state_next.refused = 1'b0;
      end
      if (go && deny) begin
         state_next.refused = 1'b1;
      end
      state_next.prdata = 32'h00000000;
      if (apb_rd) begin
         unique case (paddr)
            `APB_CMD: state_next.prdata = {16'h0000, 1'b0, state_reg.addr,
                                           state_reg.wdata} |
                                          {15'h0000, state_reg.we, 16'h0000};
            `APB_PAGE: state_next.prdata = {24'h000000, state_reg.page};
            `APB_STATUS: state_next.prdata = {16'h0000, state_reg.rdata,
                                              5'h00, link.open,
                                              state_reg.refused,
                                              state_reg.state == HOST_WAIT};
            default: state_next.prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
         state_reg.page <= `PAGE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pready = state_reg.pready;
   assign prdata = state_reg.prdata;
   assign link.req = state_reg.req;
   assign link.we = state_reg.we;
   assign link.addr = state_reg.addr;
   assign link.wdata = state_reg.wdata;
endmodule // coef_map_host

// File: sim/coef_link_asserts.sv
// Concurrent checks on the link between controller and coefficient map
`timescale 1ns/1ns

module coef_link_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire logic we,
   input wire coef_map_pkg::reg_addr_t addr,
   input wire coef_map_pkg::byte_t wdata,
   input wire logic ack,
   input wire coef_map_pkg::byte_t rdata,
   input wire logic open
);
   import coef_map_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----
   // Handshake
   // ----
   ack_one_cycle_a: assert property (
      req && !ack |=> ack) else $error("ack missing");
   ack_caused_a: assert property (
      ack |-> $past(req) && !$past(ack)) else $error("stray ack");
   req_held_a: assert property (
      req && !ack |=> req && $stable({we, addr, wdata}))
      else $error("request moved");
   req_drop_a: assert property (
      ack |=> !ack && !req) else $error("ack or req stuck");
   rdata_held_a: assert property (
      !$stable(rdata) |-> ack) else $error("rdata moved");
   // ----
   // Reserved places and gating
   // ----
   rsvd_read_a: assert property (
      req && !ack && !we && addr inside {[7'h02:7'h07]} |=> rdata == 8'h00)
      else $error("reserved read");
   lane_three_a: assert property (
      req && !ack && !we && addr >= 7'h08 && addr[1:0] == 2'b11
      |=> rdata == 8'h00) else $error("fourth byte read");
   rsvd_write_a: assert property (
      req |-> !(we && addr inside {[7'h02:7'h07]}))
      else $error("reserved write sent");
   open_gate_a: assert property (
      $rose(req) && addr >= 7'h08 |-> $past(open))
      else $error("buffer access while closed");
endmodule // coef_link_asserts

// File: sim/dac_coef_ram_paged_map_tb.sv
// Self-checking bench joining controller and coefficient map
`timescale 1ns/1ns
`include "coef_map_defs.svh"
`define CHK(nm, ex, sn) begin n_tests++; if ((sn) !== (ex)) begin \
   errors++; $display("Error %s expected %h seen %h", nm, ex, sn); end end

module dac_coef_ram_paged_map_tb;
   import coef_map_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic dac_powered = 1'b0;
   logic frame_strobe = 1'b0;
   logic [7:0] conv_idx = 8'h00;
   logic [23:0] conv_coef;
   logic conv_uses_b;
   logic adaptive_on;
   logic defaults_ready;
   logic [31:0] rnd = 32'he7221877;
   logic [7:0] corner [4] = '{8'h00, 8'h1d, 8'h1e, 8'hff};
   logic [14:0] rsv [4] = '{{8'h2c, 7'h03}, {8'h35, 7'h08},
      {8'h64, 7'h0a}, {8'h2d, 7'h01}};
   int errors = 0;
   int n_tests = 0;
   always #20 pclk = ~pclk;

   coef_link_if link ();
   coef_map_device #(.INIT_CYCLES(300)) coef_map_device_i (
      .pclk(pclk), .presetn(presetn), .link(link),
      .dac_powered(dac_powered), .frame_strobe(frame_strobe),
      .conv_idx(conv_idx), .conv_coef(conv_coef),
      .conv_uses_b(conv_uses_b), .adaptive_on(adaptive_on),
      .defaults_ready(defaults_ready));
   coef_map_host coef_map_host_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .link(link));
   coef_link_asserts coef_link_asserts_i (
      .pclk(pclk), .presetn(presetn), .req(link.req), .we(link.we),
      .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
      .rdata(link.rdata), .open(link.open));

   // ----
   // Helpers
   // ----
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
   endfunction

   task automatic complete_run;
      if (errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic hang;
      errors++;
      complete_run();
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang();
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Busy polling doubles as the wait for the link answer
   task automatic link_op(input logic w, input logic [6:0] r,
         input logic [7:0] d, output logic [7:0] q, output logic f);
      logic [31:0] s;
      int n;
      apb(1'b1, `APB_CMD, {1'b1, 14'h0, w, 1'b0, r, d}, s);
      n = 0;
      do begin
         apb(1'b0, `APB_STATUS, 32'h0, s);
         n++;
      end while (s[`ST_BUSY_BIT] !== 1'b0 && n < 20);
      if (n >= 20) hang();
      q = s[15:8];
      f = s[`ST_REFUSED_BIT];
      if (f === 1'b1) apb(1'b1, `APB_STATUS, 32'h2, s);
   endtask

   task automatic sel(input logic [7:0] p);
      logic [7:0] q;
      logic f;
      link_op(1'b1, 7'h00, p, q, f);
   endtask

   // Writes (when w) and reads back each of the four bytes of one coefficient in turn
   task automatic coef(input logic b, input logic [7:0] i,
         input logic [23:0] v, input logic w);
      logic [31:0] g;
      logic [31:0] x;
      logic [7:0] q;
      logic f;
      logic [6:0] r;
      x = {v, 8'h5a};
      r = 7'(8'h08 + 8'h04 * (i % 8'h1e));
      sel((b ? 8'h3e : 8'h2c) + i / 8'h1e);
      for (int k = 0; k < 4; k++) begin
         if (w) link_op(1'b1, r + 7'(k), x[31 - 8 * k -: 8], q, f);
         link_op(1'b0, r + 7'(k), 8'h00, q, f);
         g = {g[23:0], q};
      end
      `CHK("coef", {v, 8'h00}, g)
   endtask

   // ----
   // Scenarios
   // ----
   initial begin
      logic [31:0] s;
      logic [7:0] q;
      logic [7:0] p;
      logic [7:0] i;
      logic [23:0] va;
      logic f;
      int n;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `APB_STATUS, 32'h0, s);
      `CHK("open", 1'b0, s[`ST_OPEN_BIT])
      sel(8'h2c);
      link_op(1'b0, 7'h08, 8'h00, q, f);
      `CHK("early", 1'b1, f)
      `CHK("ready", 1'b0, defaults_ready)
      n = 0;
      while (defaults_ready !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 400) hang();
      coef(1'b0, 8'h00, 24'h0, 1'b0);
      coef(1'b1, 8'hc8, 24'h0, 1'b0);
      coef(1'b0, 8'h01, 24'h7fffff, 1'b0);
      coef(1'b1, 8'h48, 24'h100900, 1'b0);
      coef(1'b0, 8'h4c, 24'h7fde00, 1'b0);
      for (int k = 0; k < 2; k++) begin
         rnd = lfsr(rnd);
         p = k ? 8'hff : rnd[7:0];
         sel(p);
         link_op(1'b0, 7'h00, 8'h00, q, f);
         `CHK("page", p, q)
         apb(1'b0, `APB_PAGE, 32'h0, s);
         `CHK("page_copy", {24'h0, p}, s)
      end
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr(rnd);
         // Odd random index keeps coefficient 0 intact for later re-reads
         i = (k < 4) ? corner[k] : (rnd[15:8] | 8'h01);
         if (k == 0) va = rnd[23:0];
         coef(1'b0, i, rnd[23:0], 1'b1);
         coef(1'b1, i, ~rnd[23:0], 1'b1);
         conv_idx <= i;
         repeat (3) @(posedge pclk);
         `CHK("conv", rnd[23:0], conv_coef)
      end
      dac_powered <= 1'b1;
      repeat (2) @(posedge pclk);
      sel(8'h2c);
      link_op(1'b1, 7'h08, 8'h77, q, f);
      `CHK("powered", 1'b1, f)
      dac_powered <= 1'b0;
      repeat (2) @(posedge pclk);
      coef(1'b0, 8'h00, va, 1'b0);
      foreach (rsv[k]) begin
         sel(rsv[k][14:7]);
         link_op(1'b1, rsv[k][6:0], 8'hff, q, f);
         `CHK("rsvd_wr", 1'b1, f)
         link_op(1'b0, rsv[k][6:0], 8'h00, q, f);
         `CHK("rsvd_rd", 8'h00, q)
      end
      sel(8'h2c);
      link_op(1'b1, 7'h01, 8'h04, q, f);
      `CHK("adapt", 1'b1, adaptive_on)
      apb(1'b0, `APB_CMD, 32'h0, s);
      `CHK("cmd_copy", 32'h00010104, s)
      dac_powered <= 1'b1;
      rnd = lfsr(rnd);
      coef(1'b1, 8'h07, rnd[23:0], 1'b1);
      sel(8'h2c);
      link_op(1'b0, 7'h08, 8'h00, q, f);
      `CHK("conv_side", 8'h00, q)
      // Bit 1 set too: the flag must ignore it
      link_op(1'b1, 7'h01, 8'h07, q, f);
      link_op(1'b0, 7'h01, 8'h00, q, f);
      `CHK("armed", 8'h05, q)
      conv_idx <= 8'h07;
      frame_strobe <= 1'b1;
      @(posedge pclk);
      frame_strobe <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK("uses_b", 1'b1, conv_uses_b)
      `CHK("conv_b", rnd[23:0], conv_coef)
      link_op(1'b0, 7'h01, 8'h00, q, f);
      `CHK("flag", 8'h06, q)
      coef(1'b0, 8'h00, va, 1'b0);
      complete_run();
   end
endmodule // dac_coef_ram_paged_map_tb
